//--- verilog/fsb_pkg.sv
package fsb_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CFG_W = 9;
  // configuration fields, positions inside the 9-bit code (address bits 20..12)
  localparam int CFG_ADDR_LSB = 12;
  localparam int CFG_DRV_LSB = 7;
  localparam int CFG_RDY_BIT = 6;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_WAIT_LSB = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h104; // drive 10, rdy 0, cont, wait 100
  localparam logic [2:0] MODE_CONT = 3'h0;
  localparam logic [2:0] MODE_W8 = 3'h1;
  localparam logic [2:0] MODE_W16 = 3'h2;
  localparam logic [2:0] WAIT_MAX_CODE = 3'h4;
  localparam logic [3:0] WAIT_BASE = 4'h4; // first word on the 4th edge for code 000
  localparam int BANK_LSB = 18;
  // command handshake
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CFG_CMD_DATA = 8'hC0;
  localparam logic [7:0] HS_ID_OFFSET = 8'h03;
  localparam logic [15:0] HS_ID_SUPPORTED = 16'h0000;
  // chip-select gap between bursts
  localparam int CLK_NS = 100;
  localparam int CE_GAP_NS = 10;
  localparam int CE_GAP_CYC = (CE_GAP_NS + CLK_NS - 1) / CLK_NS;
  // host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_CFG = 1;
  localparam int CTRL_ABORT = 2;
  localparam int CTRL_HWRST = 3;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_STROBE = 3'h1, DS_WAIT = 3'h3, DS_BURST = 3'h2, DS_BOUND = 3'h6
  } fsb_dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_CMD1 = 3'h1, HS_CMD2 = 3'h3, HS_CMD3 = 3'h2,
    HS_STRB = 3'h6, HS_DATA = 3'h7, HS_GAP = 3'h5
  } fsb_host_st_t;

  // burst address step: linear, or wrapping inside an aligned 8/16 group
  function automatic logic [ADDR_W-1:0] fsb_next_addr(input logic [ADDR_W-1:0] a,
                                                     input logic [2:0] mode);
    logic [ADDR_W-1:0] inc;
    inc = a + 22'h000001;
    case (mode)
      MODE_W8: fsb_next_addr = {a[ADDR_W-1:3], inc[2:0]};
      MODE_W16: fsb_next_addr = {a[ADDR_W-1:4], inc[3:0]};
      default: fsb_next_addr = inc;
    endcase
  endfunction
endpackage

//--- verilog/fsb_bus_if.sv
`timescale 1ns/1ps
interface fsb_bus_if;
  import fsb_pkg::*;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic avd_n;
  logic reset_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_dq_o;
  logic host_dq_oe_n;
  logic [DATA_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic ready;
  logic [DATA_W-1:0] dq_bus;

  // resolved data wire; an undriven bus reads as all ones (pull-ups)
  assign dq_bus = !dev_dq_oe_n ? dev_dq_o : (!host_dq_oe_n ? host_dq_o : 16'hFFFF);

  modport dev (input ce_n, oe_n, we_n, avd_n, reset_n, addr, dq_bus,
               output dev_dq_o, dev_dq_oe_n, ready);
  modport host (output ce_n, oe_n, we_n, avd_n, reset_n, addr, host_dq_o, host_dq_oe_n,
                input dq_bus, ready);
endinterface

//--- verilog/fsb_flash_dev.sv
`timescale 1ns/1ps
module fsb_flash_dev
  import fsb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  fsb_bus_if.dev bus,
  output logic [fsb_pkg::ADDR_W-1:0] arr_addr,
  input wire logic [fsb_pkg::DATA_W-1:0] arr_rdata,
  input wire logic [15:0] bank_busy,
  input wire logic [fsb_pkg::DATA_W-1:0] status_word,
  input wire logic autoselect_mode,
  output logic [1:0] drive_strength,
  output logic burst_active
);
  import fsb_pkg::*;

  fsb_dev_st_t st_r, st_nxt;
  logic [CFG_W-1:0] cfg_r;
  logic [1:0] cmd_r;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] extra_r, extra_nxt;
  logic crossed_r, crossed_nxt;
  logic stat_r, stat_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic ready_r, ready_nxt;
  logic dq_oe_n_r;
  logic active_r;

  // pin qualification; writes never look like strobes
  wire hw_rst = rst | ~bus.reset_n;
  wire sel = ~bus.ce_n;
  wire wr_cyc = sel & ~bus.we_n;
  wire strobe = sel & ~bus.avd_n & bus.we_n;
  wire [11:0] cmd_lo = bus.addr[11:0];
  wire [7:0] cmd_data = bus.dq_bus[7:0];

  // configuration fields; reserved codes fall back to the defaults
  wire early_rdy = cfg_r[CFG_RDY_BIT];
  wire [2:0] mode_raw = cfg_r[CFG_MODE_LSB +: 3];
  wire [2:0] mode = (mode_raw > MODE_W16) ? MODE_CONT : mode_raw;
  wire [2:0] wait_raw = cfg_r[CFG_WAIT_LSB +: 3];
  wire [2:0] wait_code = (wait_raw > WAIT_MAX_CODE) ? WAIT_MAX_CODE : wait_raw;
  wire [3:0] lat = WAIT_BASE + {1'b0, wait_code};

  // command decoder: unlock, unlock, then C0 at 555 latches the code
  wire unlock1_hit = cmd_data == UNLOCK1_DATA && cmd_lo == UNLOCK1_ADDR;
  wire unlock2_hit = cmd_data == UNLOCK2_DATA && cmd_lo == UNLOCK2_ADDR;
  wire cfg_hit = cmd_data == CFG_CMD_DATA && cmd_lo == UNLOCK1_ADDR;
  wire [1:0] cmd_nxt = !wr_cyc ? cmd_r :
                       (cmd_r == 2'h0 && unlock1_hit) ? 2'h1 :
                       (cmd_r == 2'h1 && unlock2_hit) ? 2'h2 : 2'h0;
  wire cfg_load = wr_cyc && cmd_r == 2'h2 && cfg_hit;
  wire [CFG_W-1:0] cfg_nxt = cfg_load ? bus.addr[CFG_ADDR_LSB +: CFG_W] : cfg_r;

  // word for the current burst address: status while its bank is busy
  wire busy_hit = bank_busy[addr_r[BANK_LSB +: 4]];
  wire use_stat = stat_r | busy_hit;
  wire [DATA_W-1:0] word = use_stat ? status_word : arr_rdata;
  wire [ADDR_W-1:0] step_addr = fsb_next_addr(addr_r, mode);
  // stall count grows with the start offset in the 16-word group
  wire [3:0] start_m1 = addr_r[3:0] - 4'h1;
  wire [2:0] extra_calc = (addr_r[3:0] == 4'h0) ? 3'h0 : start_m1[3:1];
  wire at_boundary = mode == MODE_CONT && addr_r[3:0] == 4'h0 && !crossed_r;
  wire stall = at_boundary && extra_r != 3'h0;
  wire is_ident = autoselect_mode && addr_r[7:0] == HS_ID_OFFSET;

  // burst sequencer; writes never disturb it, the reset pin does
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    extra_nxt = extra_r;
    crossed_nxt = crossed_r;
    stat_nxt = stat_r;
    dq_nxt = dq_r;
    ready_nxt = ready_r;
    if (!sel) begin
      st_nxt = DS_IDLE;
      ready_nxt = 1'b0;
      stat_nxt = 1'b0;
    end else if (strobe) begin
      st_nxt = DS_STROBE;
      addr_nxt = bus.addr;
      ready_nxt = 1'b0;
      stat_nxt = 1'b0;
      crossed_nxt = 1'b0;
    end else begin
      case (st_r)
        DS_STROBE: begin
          if (autoselect_mode) begin
            // burst is barred in autoselect; answer with the id word or the array word instead
            st_nxt = DS_IDLE;
            dq_nxt = is_ident ? HS_ID_SUPPORTED : arr_rdata;
          end else begin
            st_nxt = DS_WAIT;
            cnt_nxt = 4'h1;
            extra_nxt = extra_calc;
            stat_nxt = busy_hit;
          end
        end
        DS_WAIT: begin
          cnt_nxt = cnt_r + 4'h1;
          if (early_rdy && cnt_r == lat - 4'h2) begin
            ready_nxt = 1'b1;
          end
          if (cnt_r == lat - 4'h1) begin
            st_nxt = DS_BURST;
            dq_nxt = word;
            ready_nxt = 1'b1;
            stat_nxt = use_stat;
            addr_nxt = step_addr;
            crossed_nxt = mode == MODE_CONT && addr_r[3:0] == 4'hF;
          end
        end
        DS_BURST: begin
          if (stall) begin
            st_nxt = DS_BOUND;
            cnt_nxt = {1'b0, extra_r};
            ready_nxt = early_rdy && extra_r == 3'h1;
            crossed_nxt = 1'b1;
          end else begin
            dq_nxt = word;
            ready_nxt = 1'b1;
            stat_nxt = use_stat;
            addr_nxt = step_addr;
            crossed_nxt = crossed_r | at_boundary;
          end
        end
        DS_BOUND: begin
          cnt_nxt = cnt_r - 4'h1;
          ready_nxt = early_rdy && cnt_r == 4'h2;
          if (cnt_r == 4'h1) begin
            st_nxt = DS_BURST;
            dq_nxt = word;
            ready_nxt = 1'b1;
            stat_nxt = use_stat;
            addr_nxt = step_addr;
          end
        end
        DS_IDLE: begin
          ready_nxt = 1'b0;
        end
        default: begin
          st_nxt = DS_IDLE;
        end
      endcase
    end
  end

  // command decoder and configuration; hardware reset restores defaults
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      cmd_r <= 2'h0;
      cfg_r <= CFG_RESET;
    end else begin
      cmd_r <= cmd_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // sequencer state; the reset pin ends any burst
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      st_r <= DS_IDLE;
      addr_r <= '0;
      cnt_r <= 4'h0;
      extra_r <= 3'h0;
      crossed_r <= 1'b0;
      stat_r <= 1'b0;
      dq_r <= 16'h0000;
      ready_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      extra_r <= extra_nxt;
      crossed_r <= crossed_nxt;
      stat_r <= stat_nxt;
      dq_r <= dq_nxt;
      ready_r <= ready_nxt;
    end
  end

  // drivers follow ce/oe/we one edge late, a cycle of bus turnaround
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      dq_oe_n_r <= 1'b1;
      active_r <= 1'b0;
    end else begin
      dq_oe_n_r <= ~(sel & ~bus.oe_n & bus.we_n);
      active_r <= st_nxt == DS_WAIT || st_nxt == DS_BURST || st_nxt == DS_BOUND;
    end
  end

  assign bus.dev_dq_o = dq_r;
  assign bus.dev_dq_oe_n = dq_oe_n_r;
  assign bus.ready = ready_r;
  assign arr_addr = addr_r;
  assign drive_strength = cfg_r[CFG_DRV_LSB +: 2];
  assign burst_active = active_r;
endmodule // fsb_flash_dev

//--- verilog/fsb_flash_host.sv
`timescale 1ns/1ps
module fsb_flash_host
  import fsb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  fsb_bus_if.host bus,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import fsb_pkg::*;

  fsb_host_st_t st_r, st_nxt;
  logic [ADDR_W-1:0] start_r;
  logic [CFG_W-1:0] cfg_r;
  logic [15:0] count_r, left_r, left_nxt;
  logic early_r, early_nxt;
  logic [DATA_W-1:0] data_r;
  logic avail_r, ovr_r, rdy_q_r;
  logic [3:0] gap_r, gap_nxt;
  logic ce_n_r, oe_n_r, we_n_r, avd_n_r, rst_n_r, dq_oe_n_r;
  logic [ADDR_W-1:0] a_r, a_nxt;
  logic [DATA_W-1:0] dqo_r, dqo_nxt;
  logic [31:0] rdata_r;

  // register port decode
  wire ctrl_wr = reg_wr && reg_addr == REG_CTRL;
  wire idle = st_r == HS_IDLE;
  wire go_start = ctrl_wr && reg_wdata[CTRL_START] && idle;
  wire go_cfg = ctrl_wr && reg_wdata[CTRL_CFG] && idle && !reg_wdata[CTRL_START];
  wire go_abort = ctrl_wr && reg_wdata[CTRL_ABORT];
  wire go_hwrst = ctrl_wr && reg_wdata[CTRL_HWRST];
  wire data_rd = reg_rd && reg_addr == REG_DATA;
  // with early ready the word follows the ready sample by one edge
  wire take = st_r == HS_DATA && (early_r ? rdy_q_r : bus.ready);
  wire last = take && left_r == 16'h0001;
  wire [31:0] status_word = {29'h0, ovr_r, avail_r, !idle};
  wire [31:0] rd_mux = (reg_addr == REG_ADDR) ? {10'h0, start_r} :
                       (reg_addr == REG_CFG) ? {23'h0, cfg_r} :
                       (reg_addr == REG_COUNT) ? {16'h0, count_r} :
                       (reg_addr == REG_STATUS) ? status_word :
                       (reg_addr == REG_DATA) ? {16'h0, data_r} : 32'h0;

  // sequencer and the bus values it will present next
  always_comb begin
    st_nxt = st_r;
    left_nxt = left_r;
    gap_nxt = gap_r;
    early_nxt = go_hwrst ? CFG_RESET[CFG_RDY_BIT] : early_r;
    a_nxt = a_r;
    dqo_nxt = dqo_r;
    case (st_r)
      HS_IDLE: begin
        if (go_start) begin
          st_nxt = HS_STRB;
          a_nxt = start_r;
          left_nxt = count_r;
        end else if (go_cfg) begin
          st_nxt = HS_CMD1;
          a_nxt = {10'h0, UNLOCK1_ADDR};
          dqo_nxt = {8'h00, UNLOCK1_DATA};
        end
      end
      HS_CMD1: begin
        st_nxt = HS_CMD2;
        a_nxt = {10'h0, UNLOCK2_ADDR};
        dqo_nxt = {8'h00, UNLOCK2_DATA};
      end
      HS_CMD2: begin
        st_nxt = HS_CMD3;
        a_nxt = {1'b0, cfg_r, UNLOCK1_ADDR};
        dqo_nxt = {8'h00, CFG_CMD_DATA};
      end
      HS_CMD3: begin
        st_nxt = HS_IDLE;
        early_nxt = cfg_r[CFG_RDY_BIT];
      end
      HS_STRB: begin
        st_nxt = HS_DATA;
      end
      HS_DATA: begin
        if (take) begin
          left_nxt = left_r - 16'h0001;
        end
        if (last || go_abort) begin
          st_nxt = HS_GAP;
          gap_nxt = 4'(CE_GAP_CYC);
        end
      end
      HS_GAP: begin
        gap_nxt = gap_r - 4'h1;
        if (gap_r == 4'h1) begin
          st_nxt = HS_IDLE;
        end
      end
      default: begin
        st_nxt = HS_IDLE;
      end
    endcase
  end

  // bus pins straight from flip-flops, set from the state being entered, reset_n from the hardware reset bit of CTRL
  wire nxt_wr = st_nxt == HS_CMD1 || st_nxt == HS_CMD2 || st_nxt == HS_CMD3;
  wire nxt_rd = st_nxt == HS_STRB || st_nxt == HS_DATA;
  always_ff @(posedge clk) begin
    if (rst) begin
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      avd_n_r <= 1'b1;
      dq_oe_n_r <= 1'b1;
      rst_n_r <= 1'b1;
    end else begin
      ce_n_r <= ~(nxt_wr | nxt_rd);
      oe_n_r <= ~nxt_rd;
      we_n_r <= ~nxt_wr;
      avd_n_r <= st_nxt != HS_STRB;
      dq_oe_n_r <= ~nxt_wr;
      rst_n_r <= ~go_hwrst;
    end
  end

  // sequencer, software registers and captured data
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= HS_IDLE;
      start_r <= '0;
      cfg_r <= CFG_RESET;
      count_r <= 16'h0000;
      left_r <= 16'h0000;
      early_r <= 1'b0;
      gap_r <= 4'h0;
      a_r <= '0;
      dqo_r <= 16'h0000;
      data_r <= 16'h0000;
      avail_r <= 1'b0;
      ovr_r <= 1'b0;
      rdy_q_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      left_r <= left_nxt;
      early_r <= early_nxt;
      gap_r <= gap_nxt;
      a_r <= a_nxt;
      dqo_r <= dqo_nxt;
      rdy_q_r <= bus.ready;
      rdata_r <= reg_rd ? rd_mux : 32'h0;
      if (reg_wr && reg_addr == REG_ADDR) start_r <= reg_wdata[ADDR_W-1:0];
      if (reg_wr && reg_addr == REG_CFG) cfg_r <= reg_wdata[CFG_W-1:0];
      if (reg_wr && reg_addr == REG_COUNT) count_r <= reg_wdata[15:0];
      if (take) data_r <= bus.dq_bus;
      // a new word wins over the read that clears the flag
      avail_r <= take | (avail_r & ~data_rd);
      ovr_r <= (take & avail_r & ~data_rd) | (ovr_r & ~(reg_wr && reg_addr == REG_STATUS));
    end
  end

  assign bus.ce_n = ce_n_r;
  assign bus.oe_n = oe_n_r;
  assign bus.we_n = we_n_r;
  assign bus.avd_n = avd_n_r;
  assign bus.reset_n = rst_n_r;
  assign bus.addr = a_r;
  assign bus.host_dq_o = dqo_r;
  assign bus.host_dq_oe_n = dq_oe_n_r;
  assign reg_rdata = rdata_r;
endmodule // fsb_flash_host

//--- sim/fsb_props.sv
`timescale 1ns/1ps
module fsb_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic avd_n,
  input wire logic reset_n,
  input wire logic [fsb_pkg::ADDR_W-1:0] addr,
  input wire logic [fsb_pkg::DATA_W-1:0] host_dq_o,
  input wire logic dev_dq_oe_n,
  input wire logic ready
);
  import fsb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // bus cycle decodes; the data compare looks at the low byte only, as the commands do
  wire rd_en = !ce_n && !oe_n && we_n;
  wire wr_cyc = !ce_n && !we_n;
  wire cfg_wr = wr_cyc && host_dq_o[7:0] == CFG_CMD_DATA;
  wire unl2_wr = wr_cyc && host_dq_o[7:0] == UNLOCK2_DATA && addr[11:0] == UNLOCK2_ADDR;

  // device side: quiet after any reset, bursts end at once
  rst_quiet_a: assert property ($fell(rst) |-> !ready && dev_dq_oe_n)
    else $error("device active right after reset");
  ce_stop_a: assert property (ce_n |=> !ready)
    else $error("ready still high after chip select rose");
  hw_reset_a: assert property (!reset_n |=> !ready)
    else $error("ready survived a hardware reset");
  strobe_stop_a: assert property (!avd_n && !ce_n |=> !ready)
    else $error("ready high after a new strobed address");
  // first word never before edge three, and no later than the default wait allows
  first_quiet_a: assert property ($rose(avd_n) && !ce_n |-> !ready [*3])
    else $error("first word flagged too early");
  first_due_a: assert property ($rose(avd_n) && !ce_n |-> ##[3:8] (ready || ce_n || !avd_n))
    else $error("first word flagged too late");
  drive_gate_a: assert property (!dev_dq_oe_n |-> $past(rd_en))
    else $error("device drives data without a read cycle");
  // host side: strobes and the configuration sequence
  strobe_sel_a: assert property (!avd_n |-> !ce_n && we_n)
    else $error("strobe outside a selected read");
  cfg_seq_a: assert property (cfg_wr |-> addr[11:0] == UNLOCK1_ADDR && $past(unl2_wr))
    else $error("configuration write without unlock sequence");
  gap_a: assert property ($rose(ce_n) |-> avd_n)
    else $error("strobe in the chip select gap");

  c_stall: cover property (!ce_n throughout (ready ##1 !ready [*2] ##1 ready));
  c_cfg: cover property (cfg_wr);
  c_first: cover property ($rose(avd_n) ##[3:8] ready);
endmodule // fsb_props

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  import fsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [ADDR_W-1:0] arr_addr;
  logic [DATA_W-1:0] arr_rdata;
  logic [15:0] bank_busy = 16'h0000;
  logic [DATA_W-1:0] status_word = 16'h0080;
  logic [1:0] drive_strength;
  logic autosel = 1'b0;
  logic burst_on;
  logic [DATA_W-1:0] cap_q[$];
  logic [8:0] cur = CFG_RESET;
  logic early = 1'b0;
  logic rdy_q = 1'b0;
  logic avd_q = 1'b0;
  logic [31:0] r;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int lat = 0;
  int lat_first = 0;
  int stalls = 0;
  int want = 0;

  fsb_bus_if bus ();
  // array content is a simple function of the address so every word is predictable
  assign arr_rdata = arr_addr[15:0] + 16'h1000;
  always #50 clk = ~clk;

  fsb_flash_dev u_fsb_flash_dev (.clk(clk), .rst(rst), .bus(bus.dev), .arr_addr(arr_addr),
    .arr_rdata(arr_rdata), .bank_busy(bank_busy), .status_word(status_word),
    .autoselect_mode(autosel), .drive_strength(drive_strength), .burst_active(burst_on));
  fsb_flash_host u_fsb_flash_host (.clk(clk), .rst(rst), .bus(bus.host), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fsb_props u_fsb_props (.clk(clk), .rst(rst), .ce_n(bus.ce_n), .oe_n(bus.oe_n),
    .we_n(bus.we_n), .avd_n(bus.avd_n), .reset_n(bus.reset_n), .addr(bus.addr),
    .host_dq_o(bus.host_dq_o), .dev_dq_oe_n(bus.dev_dq_oe_n), .ready(bus.ready));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // wire monitor; early ready leads data by one edge, so it is delayed to line up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdy_q <= bus.ready;
    avd_q <= bus.avd_n;
    lat <= (bus.avd_n && !avd_q) ? 1 : lat + 1;
    if (!bus.ce_n && (early ? rdy_q : bus.ready) === 1'b1) begin
      if (cap_q.size() == 0) lat_first <= lat;
      cap_q.push_back(bus.dq_bus);
    end else if (!bus.ce_n && cap_q.size() > 0 && cap_q.size() < want) begin
      stalls <= stalls + 1;
    end
    if (cyc >= 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // bounded poll; a stuck busy flag shows up as a mismatch, not a hang
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    rd(REG_STATUS, s);
    while (s[0] !== 1'b0 && n < 200) begin
      rd(REG_STATUS, s);
      n++;
    end
    chk("idle", 32'h0, {31'h0, s[0]});
  endtask

  task automatic load(input logic [8:0] c);
    wr(REG_CFG, {23'h0, c});
    wr(REG_CTRL, 32'h2);
    wait_idle();
    cur = c;
    early = c[CFG_RDY_BIT];
  endtask

  // one burst, compared with the address walk that the current setting implies
  task automatic burst(input logic [21:0] a, input int n, input logic sts);
    logic [21:0] x;
    logic [2:0] m;
    logic [2:0] w;
    int e;
    x = a;
    m = (cur[5:3] > MODE_W16) ? MODE_CONT : cur[5:3];
    w = (cur[2:0] > WAIT_MAX_CODE) ? WAIT_MAX_CODE : cur[2:0];
    // a start on the last word of a group counts as already across, so no stall
    e = (m == MODE_CONT && a[3:0] > 4'h1 && a[3:0] != 4'hF && n > 16 - a[3:0]) ?
        (a[3:0] - 4'h1) >> 1 : 0;
    cap_q.delete();
    stalls = 0;
    want = n;
    wr(REG_ADDR, {10'h0, a});
    wr(REG_COUNT, n);
    wr(REG_CTRL, 32'h1);
    wait_idle();
    for (int i = 0; i < n; i++) begin
      chk("word", {16'h0, sts ? status_word : x[15:0] + 16'h1000}, {16'h0, cap_q[i]});
      case (m)
        MODE_W8: x = {x[21:3], x[2:0] + 3'h1};
        MODE_W16: x = {x[21:4], x[3:0] + 4'h1};
        default: x = x + 22'h1;
      endcase
    end
    if (!sts) begin
      chk("stall", e, stalls);
      chk("latency", 4 + w, lat_first);
    end
  endtask

  // autoselect: a strobe gives no burst and no ready, only the id or array word
  task automatic ident(input logic [21:0] a, input logic [15:0] exp);
    wr(REG_ADDR, {10'h0, a});
    wr(REG_COUNT, 32'h1);
    wr(REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("ident", {16'h0, exp}, {16'h0, bus.dq_bus});
    chk("ident ready", 32'h0, {31'h0, bus.ready});
    wr(REG_CTRL, 32'h4);
    wait_idle();
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(REG_STATUS, r);
    chk("status", 32'h0, r);
    rd(8'h18, r);
    chk("unmapped", 32'h0, r);
    chk("drive", 32'h2, {30'h0, drive_strength});
    load(CFG_RESET);
    burst(22'h000003, 20, 1'b0);
    burst(22'h3FFFFE, 4, 1'b0);
    // wait codes 0 to 5, reserved code 5 among them, in both ready modes, aligned start
    for (int i = 0; i < 12; i++) begin
      load({2'b10, i[0], 3'h0, 3'(i >> 1)});
      burst(22'h000020, 3, 1'b0);
    end
    for (int m = 1; m < 8; m++) begin
      load({2'b10, 1'b0, 3'(m), 3'h0});
      burst(22'h00001A + 22'(m), 12, 1'b0);
    end
    for (int d = 0; d < 4; d++) begin
      load({2'(d), 7'h04});
      chk("drive", d, {30'h0, drive_strength});
    end
    wr(REG_CTRL, 32'h8);
    wait_idle();
    cur = CFG_RESET;
    early = 1'b0;
    chk("drive", 32'h2, {30'h0, drive_strength});
    burst(22'h000040, 3, 1'b0);
    // last word stays readable; earlier unread words have left the overrun flag up
    rd(REG_DATA, r);
    chk("data", 32'h1042, r);
    rd(REG_STATUS, r);
    chk("status", 32'h4, r);
    wr(REG_STATUS, 32'h0);
    rd(REG_STATUS, r);
    chk("status", 32'h0, r);
    // busy bank gives status words; a fresh strobe afterwards reads the array again
    bank_busy <= 16'h0004;
    burst(22'h080010, 5, 1'b1);
    bank_busy <= 16'h0000;
    burst(22'h080010, 5, 1'b0);
    autosel <= 1'b1;
    ident(22'h080003, HS_ID_SUPPORTED);
    ident(22'h080004, 16'h1004);
    autosel <= 1'b0;
    // open-ended burst stopped by abort
    cap_q.delete();
    want = 0;
    wr(REG_ADDR, 32'h100);
    wr(REG_COUNT, 32'h0);
    wr(REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    chk("active", 32'h1, {31'h0, burst_on});
    wr(REG_CTRL, 32'h4);
    wait_idle();
    chk("active", 32'h0, {31'h0, burst_on});
    chk("abort word", 32'h1100, {16'h0, cap_q[0]});
    report_and_stop();
  end
endmodule // tb
